/* File: pkg/amseq_pkg.sv */
package amseq_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the apb port)
  // ----------------------------------------------------------------
  localparam logic [15:0] AFE_ADDR  = 16'h210C; // front-end pin setup
  localparam logic [15:0] RATE_ADDR = 16'h2200; // converter rate select
  localparam logic [15:0] SEQ_ADDR  = 16'h2204; // input per state
  localparam logic [15:0] FRM_ADDR  = 16'h2208; // state count, dec len
  localparam logic [15:0] STAT_ADDR = 16'h220C; // sequencer position

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PREAMP_BIT = 0;  // gain 8 on first pair
  localparam int FDIFF_BIT  = 4;  // first_pair_diff_enable
  localparam int PDIFF_LSB  = 5;  // pair_diff_enable, pairs 2..4
  localparam int RMT_BIT    = 8;  // remote_sensor_enable
  localparam int AFE_W      = 9;  // width of the front-end word
  localparam int RATE_BIT   = 5;  // bias / rate select
  localparam int CNT_LSB    = 0;  // frame_state_count [3:0]
  localparam int DLEN_LSB   = 4;  // decimation_length [1:0]
  localparam int FRM_W      = 6;  // width of the frame word
  localparam int SEQ_W      = 28; // seven 4-bit input codes

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [8:0]  AFE_RST  = 9'h010;      // first pair diff
  localparam logic        RATE_RST = 1'h0;        // low bias
  localparam logic [5:0]  FRM_RST  = 6'h26;       // 6 states, 22 bit
  localparam logic [27:0] SEQ_RST  = 28'hFFF6540; // i0 va vb vc - -

  // ----------------------------------------------------------------
  // input codes, slots and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_VOLT0  = 4'h4; // first voltage code
  localparam logic [3:0] SEL_LAST   = 4'h6; // last legal code
  localparam logic [3:0] SLOT_VOLT0 = 4'h8; // first voltage slot
  localparam int MAX_STATES  = 7; // inputs per frame
  localparam int STATE_TICKS = 2; // slow clock cycles per state
  localparam int FIR_SHIFT   = 9; // result left shift

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_TAIL
  } amseq_state_e;

  // one write into compute-engine sample ram
  typedef struct packed {
    logic        vld;     // write strobe
    logic        remote;  // sample came from a remote sensor
    logic        current; // current sample (delayed one interval)
    logic [3:0]  slot;    // result slot
    logic [31:0] data;    // shifted signed result
  } amseq_ce_wr_s;
endpackage : amseq_pkg

/* File: sim/amseq_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// slow reference, decimation filter and remote sensors
// -----------------------------------------------------------------
module amseq_partner #(
  parameter int HALF_NS = 410 // slow clock half period in ns
) (
  input  wire logic             clk_i,
  input  wire logic             conv_start_i,
  input  wire logic [3:0]       conv_sel_i,
  input  wire logic             frame_start_i,
  input  wire logic             slow_ans_i,
  input  wire logic             rmt_go_i,
  output logic                  slow_clk_o,
  output logic                  conv_done_o,
  output logic      [21:0]      conv_data_o,
  output logic      [2:0]       rmt_valid_o,
  output logic      [2:0][21:0] rmt_data_o
);
  logic [3:0] code; // input code caught at launch
  initial begin
    slow_clk_o  = 1'b0;
    conv_done_o = 1'b0;
    conv_data_o = 22'h155555;
    rmt_valid_o = 3'h0;
    rmt_data_o  = '0;
  end
  // free running reference; made fast so a run stays short
  always #(HALF_NS) slow_clk_o = ~slow_clk_o;
  // filter answers each launch, bit 20 set so length matters
  always @(posedge clk_i) begin
    if (conv_start_i === 1'b1) begin
      code = conv_sel_i;
      repeat (slow_ans_i ? 30 : 1) @(posedge clk_i);
      conv_data_o <= {2'b01, 16'h0ABC, code};
      conv_done_o <= 1'b1;
      @(posedge clk_i);
      conv_done_o <= 1'b0;
      conv_data_o <= ~conv_data_o; // stale data is not kept
    end
  end
  // one sample per remote pair early in each frame
  always @(posedge clk_i) begin
    if (frame_start_i === 1'b1 && rmt_go_i) begin
      for (int k = 0; k < 3; k++) begin
        repeat (4) @(posedge clk_i);
        rmt_data_o[k]  <= 22'h00A000 | 22'(k);
        rmt_valid_o[k] <= 1'b1;
        @(posedge clk_i);
        rmt_valid_o[k] <= 1'b0;
        rmt_data_o[k]  <= ~rmt_data_o[k];
      end
    end
  end
endmodule : amseq_partner
`default_nettype wire

/* File: sim/amseq_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module amseq_top_tb;
  import amseq_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed nets
  // ---------------------------------------------------------------
  localparam int HALF = 405; // rising slow edges never meet a clk edge; falling ones land on one
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic er, lat = 1'b0, rgo = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, perr, slck, cdone, cstart, fstart, pre, fdf, bias;
  wire logic [21:0] cdata;
  wire logic [2:0] rval, pdf, rif;
  wire logic [2:0][21:0] rdat;
  wire logic [3:0] csel;
  wire logic [1:0] dlen;
  wire amseq_ce_wr_s cew;
  int err_count = 0;
  int total_checks = 0;
  logic [3:0] w_slot[$], s_sel[$];
  logic [31:0] w_data[$];
  logic [1:0] w_flg[$];
  time w_t[$], s_t[$], fs_t[$];
  always #10 clk = ~clk;
  amseq_top u_amseq_top (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .SLOW_CLK_I(slck), .CONV_DONE_I(cdone), .CONV_DATA_I(cdata),
    .RMT_VALID_I(rval), .RMT_DATA_I(rdat), .CONV_START_O(cstart),
    .CONV_SEL_O(csel), .FRAME_START_O(fstart), .PREAMP_GAIN8_O(pre),
    .FIRST_DIFF_O(fdf), .PAIR_DIFF_O(pdf), .REMOTE_IF_EN_O(rif),
    .BIAS_SEL_O(bias), .DEC_LEN_O(dlen), .CE_WR_O(cew));
  amseq_partner #(.HALF_NS(HALF)) u_amseq_partner (.clk_i(clk),
    .conv_start_i(cstart), .conv_sel_i(csel), .frame_start_i(fstart),
    .slow_ans_i(lat), .rmt_go_i(rgo), .slow_clk_o(slck),
    .conv_done_o(cdone), .conv_data_o(cdata), .rmt_valid_o(rval),
    .rmt_data_o(rdat));
  // ---------------------------------------------------------------
  // monitor: every ram write, launch and frame start, with time
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (cew.vld === 1'b1) begin
      w_slot.push_back(cew.slot);
      w_data.push_back(cew.data);
      w_flg.push_back({cew.remote, cew.current});
      w_t.push_back($time);
    end
    if (cstart === 1'b1) begin
      s_sel.push_back(csel);
      s_t.push_back($time);
    end
    if (fstart === 1'b1) fs_t.push_back($time);
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (2) @(negedge clk); // let config levels settle
  endtask : apb
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'h0);
  endtask : rdchk
  function automatic logic [31:0] exp_d(input logic [21:0] r,
                                        input logic [1:0] len);
    logic [31:0] s;
    s = (len == 2'h1) ? {{11{r[20]}}, r[20:0]} : {{10{r[21]}}, r};
    return s << 9;
  endfunction : exp_d
  // watch one whole frame and compare launches and writes
  task automatic frame(input int n, input logic [3:0] c [7],
                       input logic [1:0] len, input int nrem);
    logic [3:0] es[$];
    logic [31:0] ed[$];
    int j, k, nloc;
    time t0, t1;
    @(negedge clk);
    w_slot.delete(); w_data.delete(); w_flg.delete(); w_t.delete();
    s_sel.delete(); s_t.delete(); fs_t.delete();
    k = 0;
    while (fs_t.size() < 3 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (fs_t.size() < 3) begin
      chk(32'h0, 32'h1);
      return;
    end
    t0 = fs_t[1];
    t1 = fs_t[2];
    k = (2 * n + 1) * 2 * HALF;
    chk(32'(t1 - t0 > k - 50 && t1 - t0 < k + 50), 32'h1);
    j = 0;
    foreach (s_sel[i]) if (s_t[i] >= t0 && s_t[i] < t1) begin
      chk(32'(s_sel[i]), 32'(c[j]));
      j++;
    end
    chk(j, n);
    for (int i = 0; i < n; i++) if (c[i] <= SEL_LAST) begin
      es.push_back(c[i] < SEL_VOLT0 ? c[i] << 1 : c[i] + 4'h4);
      ed.push_back(exp_d({2'b01, 16'h0ABC, c[i]}, len));
    end
    nloc = es.size();
    for (int i = 0; i < nrem; i++) begin
      es.push_back(4'(2 * i + 2));
      ed.push_back((32'h00A000 | 32'(i)) << 9);
    end
    j = 0;
    foreach (w_slot[i]) if (w_t[i] >= t0 && w_t[i] < t1) begin
      chk(32'(w_slot[i]), 32'(es[j]));
      chk(w_data[i], ed[j]);
      chk(32'(w_flg[i]), 32'({j >= nloc, es[j] < SLOT_VOLT0}));
      if (j >= nloc) chk(32'(w_t[i] - t0 > n * 2 * HALF), 32'h1);
      j++;
    end
    chk(j, es.size());
  endtask : frame
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] tr [7];
    logic [3:0] rm [7];
    tr = '{4'h1, 4'h4, 4'h2, 4'h5, 4'h3, 4'h6, 4'h0};
    rm = '{4'h0, 4'h4, 4'h5, 4'h6, 4'hF, 4'hF, 4'hF};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(AFE_ADDR, 32'h010);
    rdchk(RATE_ADDR, 32'h0);
    rdchk(FRM_ADDR, 32'h26);
    rdchk(SEQ_ADDR, 32'hFFF6540);
    chk(32'({fdf, dlen}), 32'h6);
    apb(1'b0, 16'h2210, 32'h0); // unmapped read
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, 16'h2214, 32'h5); // unmapped write
    chk(32'(er), 32'h1);
    apb(1'b1, AFE_ADDR, 32'h001); // gain 8, single ended
    chk(32'({pre, fdf}), 32'h2);
    apb(1'b1, RATE_ADDR, 32'h20);
    chk(32'(bias), 32'h1);
    rdchk(RATE_ADDR, 32'h20);
    apb(1'b1, RATE_ADDR, 32'h0);
    chk(32'(bias), 32'h0);
    // transformers: current then its voltage, slow filter answer
    apb(1'b1, SEQ_ADDR, 32'h0635241);
    apb(1'b1, FRM_ADDR, 32'h27);
    apb(1'b1, AFE_ADDR, 32'h0F0);
    chk(32'({pre, fdf, pdf, rif, dlen}), 32'h1E2);
    lat <= 1'b1;
    rgo <= 1'b1;
    frame(7, tr, 2'h2, 0);
    // remote pairs, local neutral with gain, prompt answers
    apb(1'b1, SEQ_ADDR, 32'hFFF6540);
    apb(1'b1, FRM_ADDR, 32'h16);
    apb(1'b1, AFE_ADDR, 32'h111);
    chk(32'({pre, fdf, pdf, rif, dlen}), 32'h31D);
    lat <= 1'b0;
    frame(6, rm, 2'h1, 3);
    results();
  end
  initial begin
    #(1_000_000);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    results();
  end
endmodule : amseq_top_tb
`default_nettype wire

/* File: src/amseq_top.sv */
// Overview of operation
// RULE1: frame starts state 1, runs programmed count
// RULE2: at most seven inputs per frame
// RULE3: remote arrangement: first pair differential, others remote
// RULE4: transformer arrangement: all four pairs differential
// RULE5: remote arrangement frame lasts 13 slow cycles
// RULE6: remote samples written in frame second half
// RULE7: remote frame holds two unused slots
// RULE8: local arrangement frame lasts 15 slow cycles
// RULE9: program current then matching voltage
// RULE10: tag current samples for one-interval delay
// RULE11: first pair result to slot 0 only
// RULE12: other pairs write even slot only
// RULE13: voltages single-ended, slots 8, 9, 10
// RULE14: preamp enable gives gain 8 on pair one
// RULE15: preamp independent of differential enable
// RULE16: bias follows rate select bit
// RULE17: 21 or 22 bit signed by length
// RULE18: launch each conversion, store at its slot
// RULE19: results shifted left nine bits
// RULE20: remote enable turns pairs two-four digital
// RULE21: unused slots write nothing
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module amseq_top #(
  parameter int MAX_ST = amseq_pkg::MAX_STATES // states per frame
) (
  input  wire logic                     REF_CLK_I,
  input  wire logic                     RESET_N_I,
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [15:0]              PADDR_I,
  input  wire logic [31:0]              PWDATA_I,
  output logic      [31:0]              PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  input  wire logic                     SLOW_CLK_I,
  input  wire logic                     CONV_DONE_I,
  input  wire logic [21:0]              CONV_DATA_I,
  input  wire logic [2:0]               RMT_VALID_I,
  input  wire logic [2:0][21:0]         RMT_DATA_I,
  output logic                          CONV_START_O,
  output logic      [3:0]               CONV_SEL_O,
  output logic                          FRAME_START_O,
  output logic                          PREAMP_GAIN8_O,
  output logic                          FIRST_DIFF_O,
  output logic      [2:0]               PAIR_DIFF_O,
  output logic      [2:0]               REMOTE_IF_EN_O,
  output logic                          BIAS_SEL_O,
  output logic      [1:0]               DEC_LEN_O,
  output amseq_pkg::amseq_ce_wr_s       CE_WR_O
);
  import amseq_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // state index is three bits wide and the table holds seven codes
  if (MAX_ST < 1 || MAX_ST > MAX_STATES) begin : g_bad_max
    $error("MAX_ST must lie between 1 and 7");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address match, used for every register
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  // result slot of an input code: pairs even, voltages 8..10
  function automatic logic [3:0] slot_of(input logic [3:0] s);
    if (s < SEL_VOLT0) begin
      slot_of = {s[2:0], 1'b0};                    // [RULE11] [RULE12]
    end else begin
      slot_of = s - SEL_VOLT0 + SLOT_VOLT0;        // [RULE13]
    end
  endfunction : slot_of

  // sign extension by decimation length, then fixed shift
  function automatic logic [31:0] fir_word(input logic [21:0] d,
                                           input logic [1:0]  len);
    logic [22:0] e;
    e = (len == 2'h1) ? {{2{d[20]}}, d[20:0]}      // [RULE17]
                      : {d[21], d};
    fir_word = {e, {FIR_SHIFT{1'b0}}};             // [RULE19]
  endfunction : fir_word

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [AFE_W-1:0] afe_q;       // front-end control word
  logic             rate_q;      // rate / bias select
  logic [FRM_W-1:0] frm_q;       // state count and length
  logic [SEQ_W-1:0] seq_q;       // input code per state
  logic             pready_q;    // apb ready, one wait state
  logic [31:0]      prdata_q;    // latched read data
  logic             pslverr_q;   // unmapped address
  logic             s1_q;        // slow clock sync, first stage
  logic             s2_q;        // slow clock sync, second stage
  logic             s3_q;        // edge detect delay
  amseq_state_e     st_q;
  amseq_state_e     st_d;
  logic [2:0]       idx_q;       // current state, 1-based
  logic [2:0]       idx_d;
  logic [2:0]       nfr_q;       // state count held for the frame
  logic [2:0]       nfr_d;
  logic             ph_q;        // tick within a state
  logic             ph_d;
  logic [4:0]       ft_q;        // tick within the frame
  logic [4:0]       ft_d;
  logic [3:0]       sel_q;       // selected input code
  logic [3:0]       sel_d;
  logic             start_q;     // conversion launch pulse
  logic             start_d;
  logic             fst_q;       // frame start pulse
  logic             fst_d;
  logic [2:0]       pend_q;      // remote sample waiting
  logic [2:0]       pend_d;
  logic [21:0]      rmt_q [3];   // held remote samples
  amseq_ce_wr_s     ce_q;
  amseq_ce_wr_s     ce_d;
  logic [2:0]       clr;         // remote sample being written

  // ----------------------------------------------------------------
  // decode and selection
  // ----------------------------------------------------------------
  wire        acc     = PSEL_I & PENABLE_I;
  wire        done    = acc & pready_q;
  wire        wr      = done & PWRITE_I;
  wire        h_afe   = hit(PADDR_I, AFE_ADDR);
  wire        h_rate  = hit(PADDR_I, RATE_ADDR);
  wire        h_seq   = hit(PADDR_I, SEQ_ADDR);
  wire        h_frm   = hit(PADDR_I, FRM_ADDR);
  wire        h_stat  = hit(PADDR_I, STAT_ADDR);
  wire        mapped  = h_afe | h_rate | h_seq | h_frm | h_stat;
  wire [31:0] rdata   = h_afe  ? 32'(afe_q)
                      : h_rate ? 32'(rate_q) << RATE_BIT
                      : h_seq  ? 32'(seq_q)
                      : h_frm  ? 32'(frm_q)
                      : h_stat ? {21'h0, pend_q, ft_q, idx_q}
                      : 32'h0;
  wire        rmt     = afe_q[RMT_BIT];
  wire [3:0]  cnt     = frm_q[CNT_LSB +: 4];
  wire [1:0]  dlen    = frm_q[DLEN_LSB +: 2];
  wire [2:0]  n_eff   = (cnt > 4'(MAX_ST)) ? 3'(MAX_ST)   // [RULE2]
                                           : cnt[2:0];
  wire        tick    = s2_q & ~s3_q;
  wire        ph_last = (ph_q == 1'(STATE_TICKS - 1));
  // code for the state after idx_q; padding reads as unused
  wire [31:0] seq_x   = {4'hF, seq_q};
  wire [3:0]  nxt_sel = seq_x[{idx_q, 2'b00} +: 4];
  // a pair whose pins are digital is skipped, like an unused code
  wire        sel_ok  = (sel_q <= SEL_LAST) &&       // [RULE7]
                        !(rmt && sel_q != 4'h0 && sel_q < SEL_VOLT0);
  wire        loc_wr  = CONV_DONE_I & sel_ok;            // [RULE21]
  wire        half    = (st_q != SEQ_IDLE) && (ft_q > 5'(nfr_q));
  wire [2:0]  rpick   = pend_q & {3{half & rmt}};        // [RULE6]
  wire [1:0]  rsel    = rpick[0] ? 2'h0 : rpick[1] ? 2'h1 : 2'h2;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // ready rises one cycle into the access phase
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q & ~PWRITE_I) ? rdata : prdata_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
    end
  end

  // register writes at the completing edge only
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      afe_q  <= AFE_RST;
      rate_q <= RATE_RST;
      frm_q  <= FRM_RST;
      seq_q  <= SEQ_RST;
    end else begin
      if (wr && h_afe) begin
        afe_q <= PWDATA_I[AFE_W-1:0];
      end
      if (wr && h_rate) begin
        rate_q <= PWDATA_I[RATE_BIT];
      end
      if (wr && h_frm) begin
        frm_q <= PWDATA_I[FRM_W-1:0];
      end
      if (wr && h_seq) begin
        seq_q <= PWDATA_I[SEQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // slow reference clock
  // ----------------------------------------------------------------
  // pin from another domain: two flops, then an edge detector
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= SLOW_CLK_I;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // each state lasts two ticks, the frame ends with one idle tick;
  // so six states give 13 ticks and seven give 15
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    nfr_d   = nfr_q;
    ph_d    = ph_q;
    ft_d    = ft_q;
    sel_d   = sel_q;
    start_d = 1'b0;
    fst_d   = 1'b0;
    if (tick) begin
      ft_d = ft_q + 5'h1;
      unique case (st_q)
        SEQ_RUN: begin
          if (!ph_last) begin
            ph_d = ph_q + 1'b1;
          end else if (idx_q >= nfr_q) begin
            st_d = SEQ_TAIL;                       // [RULE5] [RULE8]
          end else begin
            ph_d    = 1'b0;
            idx_d   = idx_q + 3'h1;                // [RULE1]
            sel_d   = nxt_sel;
            start_d = 1'b1;                        // [RULE18]
          end
        end
        SEQ_IDLE, SEQ_TAIL: begin
          // a zero count parks the sequencer
          st_d    = (n_eff == 3'h0) ? SEQ_IDLE : SEQ_RUN;
          idx_d   = 3'h1;                          // [RULE1]
          // count taken here, so a mid-frame write cannot bend a frame
          nfr_d   = n_eff;
          ph_d    = 1'b0;
          ft_d    = 5'h0;
          sel_d   = seq_q[3:0];
          start_d = (n_eff != 3'h0);               // [RULE18]
          fst_d   = (n_eff != 3'h0);
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q    <= SEQ_IDLE;
      idx_q   <= 3'h0;
      nfr_q   <= 3'h0;
      ph_q    <= 1'b0;
      ft_q    <= 5'h0;
      sel_q   <= 4'hF;
      start_q <= 1'b0;
      fst_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      nfr_q   <= nfr_d;
      ph_q    <= ph_d;
      ft_q    <= ft_d;
      sel_q   <= sel_d;
      start_q <= start_d;
      fst_q   <= fst_d;
    end
  end

  // ----------------------------------------------------------------
  // sample ram writes
  // ----------------------------------------------------------------
  // local result wins the port; remote samples wait for a free cycle
  always_comb begin
    ce_d = '0;
    clr  = 3'h0;
    if (loc_wr) begin
      ce_d.vld     = 1'b1;                         // [RULE18]
      ce_d.current = (sel_q < SEL_VOLT0);          // [RULE10]
      ce_d.slot    = slot_of(sel_q);
      ce_d.data    = fir_word(CONV_DATA_I, dlen);
    end else if (rpick != 3'h0) begin
      ce_d.vld     = 1'b1;                         // [RULE6]
      ce_d.remote  = 1'b1;
      ce_d.current = 1'b1;                         // [RULE10]
      ce_d.slot    = slot_of(4'({2'b00, rsel} + 4'h1));
      ce_d.data    = fir_word(rmt_q[rsel], dlen);
      clr          = 3'(3'h1 << rsel);
    end
    // a new sample in the clearing cycle keeps its flag
    pend_d = (pend_q & ~clr) | (RMT_VALID_I & {3{rmt}});
  end

  // write port and pending flags
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ce_q   <= '0;
      pend_q <= 3'h0;
    end else begin
      ce_q   <= ce_d;
      pend_q <= pend_d;
    end
  end

  // remote sample holding, one per pair
  for (genvar k = 0; k < 3; k++) begin : g_rmt
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        rmt_q[k] <= 22'h0;
      end else if (RMT_VALID_I[k]) begin
        rmt_q[k] <= RMT_DATA_I[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA_O       = prdata_q;
  assign PREADY_O       = pready_q;
  assign PSLVERR_O      = pslverr_q;
  assign CONV_START_O   = start_q;
  assign CONV_SEL_O     = sel_q;
  assign FRAME_START_O  = fst_q;
  assign PREAMP_GAIN8_O = afe_q[PREAMP_BIT];       // [RULE14] [RULE15]
  assign FIRST_DIFF_O   = afe_q[FDIFF_BIT];        // [RULE15]
  assign PAIR_DIFF_O    = afe_q[PDIFF_LSB +: 3];
  assign REMOTE_IF_EN_O = {3{afe_q[RMT_BIT]}};     // [RULE20]
  assign BIAS_SEL_O     = rate_q;                  // [RULE16]
  assign DEC_LEN_O      = dlen;
  assign CE_WR_O        = ce_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  frame_len_a: assert property (tick && st_q == SEQ_TAIL |-> // [RULE5]
      ft_q == 5'(STATE_TICKS * nfr_q))
    else $error("frame length wrong");
  first_state_a: assert property (fst_q |-> // [RULE1]
      idx_q == 3'h1 && start_q && sel_q == $past(seq_q[3:0]))
    else $error("frame did not open at state 1");
  state_step_a: assert property (start_q && !fst_q |-> // [RULE1]
      idx_q == $past(idx_q) + 3'h1)
    else $error("state skipped");
  max_state_a: assert property (st_q != SEQ_IDLE |-> // [RULE2]
      idx_q >= 3'h1 && idx_q <= 3'(MAX_ST))
    else $error("state index out of range");
  odd_slot_a: assert property (CE_WR_O.vld && // [RULE12]
      CE_WR_O.slot < SLOT_VOLT0 |-> !CE_WR_O.slot[0])
    else $error("odd pair slot written");
  volt_slot_a: assert property (CONV_DONE_I && // [RULE13]
      sel_q >= SEL_VOLT0 && sel_q <= SEL_LAST |=>
      CE_WR_O.vld && !CE_WR_O.remote && !CE_WR_O.current &&
      CE_WR_O.slot == $past(sel_q) + 4'h4)
    else $error("voltage slot wrong");
  unused_a: assert property (CONV_DONE_I && sel_q > SEL_LAST |=> // [RULE21]
      !(CE_WR_O.vld && !CE_WR_O.remote))
    else $error("unused slot wrote ram");
  rmt_half_a: assert property (CE_WR_O.remote |-> // [RULE6]
      $past(half) && CE_WR_O.vld)
    else $error("remote write outside second half");
  shift_a: assert property (CE_WR_O.vld |-> // [RULE19]
      CE_WR_O.data[FIR_SHIFT-1:0] == 9'h000)
    else $error("result not shifted");
  width_a: assert property (CE_WR_O.vld && $past(dlen) == 2'h1 |-> // [RULE17]
      CE_WR_O.data[31:29] == {3{CE_WR_O.data[29]}})
    else $error("short result not sign extended");

  six_frame_c: cover property (tick && st_q == SEQ_TAIL && n_eff == 3'h6);
  seven_frame_c: cover property (tick && st_q == SEQ_TAIL && n_eff == 3'h7);
  rmt_write_c: cover property (CE_WR_O.remote ##1 CE_WR_O.remote);
  clash_c: cover property (loc_wr && rpick != 3'h0);
endmodule : amseq_top
`default_nettype wire
